// ==== include/pixel_pack_pkg.sv ====
// constants, codes and carriers for the tap reorder and pixel packer
// assumes one pixel clock domain shared by every user of this package
package pixel_pack_pkg;
  // line buffer, sample and output fifo geometry
  localparam int LINE_MAX   = 64;
  localparam int IDX_W      = 6;
  localparam int CNT_W      = 7;
  localparam int ADC_W      = 14;
  localparam int PIX_W      = 12;
  localparam int ADC_DROP   = 2;
  localparam int CHANNELS   = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 10;
  // tap count codes
  localparam logic [1:0] TAPS_ONE = 2'h1;
  localparam logic [1:0] TAPS_TWO = 2'h2;
  // output packing codes
  localparam logic [4:0] FMT_MONO8    = 5'h00;
  localparam logic [4:0] FMT_MONO10   = 5'h01;
  localparam logic [4:0] FMT_MONO10P  = 5'h02;
  localparam logic [4:0] FMT_MONO12   = 5'h03;
  localparam logic [4:0] FMT_MONO12P  = 5'h04;
  localparam logic [4:0] FMT_BG8      = 5'h05;
  localparam logic [4:0] FMT_BG12P    = 5'h09;
  localparam logic [4:0] FMT_RG8      = 5'h0a;
  localparam logic [4:0] FMT_RG12P    = 5'h0e;
  localparam logic [4:0] FMT_YUV      = 5'h0f;
  localparam logic [4:0] FMT_YUYV     = 5'h10;
  // bayer line pattern after reset and after each frame start
  localparam logic PATTERN_GR_FIRST = 1'b1;

  typedef enum logic [2:0] {PK_8, PK_10, PK_10P, PK_12, PK_12P} packing_t;

  typedef struct packed {
    logic                             valid;
    logic [CHANNELS-1:0][ADC_W-1:0]   ch;
  } adc_beat_t;

  typedef struct packed {
    logic       last;
    logic       pattern_gr;
    logic [7:0] data;
  } fb_word_t;

  typedef struct packed {
    logic       done;
    logic [7:0] data;
  } pack_out_t;
endpackage

// ==== rtl/byte_fifo.sv ====
// small flip-flop fifo with valid/ready on both sides
// assumes a single clock and a synchronous active high reset
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        do_push;
  logic        do_pop;

  // full and empty come straight from the occupancy count
  assign in_ready  = (s_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data  = s_reg.mem[s_reg.rd];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // pointers wrap because the depth is a power of two
  always_comb
  begin
    s_next = s_reg;
    if (do_push)
    begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (do_pop)
      s_next.rd = s_reg.rd + 1'b1;
    if (do_push && !do_pop)
      s_next.cnt = s_reg.cnt + 1'b1;
    else if (do_pop && !do_push)
      s_next.cnt = s_reg.cnt - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
endmodule

// ==== rtl/pixel_tap_reorder_packer.sv ====
// tap reorder line buffer, 14 to 12 bit reduction and pixel byte packer
// assumes converter beats arrive from pins and frame buffer takes bytes
//
// Behaviour
// - dual tap: left half left, right half right
// - tap count one or two selects readout
// - single tap uses left amplifier only
// - release line only after it is complete
// - four channel mode fills one ordered line
// - full line is packed per format afterwards
// - drop two lsbs of each 14-bit sample
// - 10-bit drops two, 8-bit drops four
// - mono and bayer formats all supported
// - mono 8 is one byte per pixel
// - 10-bit unpacked uses two bytes
// - 10-bit packed: two pixels in three bytes
// - 12-bit unpacked uses two bytes
// - 12-bit packed: two pixels in three bytes
// - bayer packs exactly like mono
// - bayer line patterns alternate each line
`timescale 1ns/1ps
module pixel_tap_reorder_packer (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // configuration
  input  wire logic [1:0]                    tap_count_select,
  input  wire logic                          quad_channel_select,
  input  wire logic [4:0]                    output_packing_select,
  input  wire logic [pixel_pack_pkg::CNT_W-1:0] line_width,
  // converter pins
  input  wire pixel_pack_pkg::adc_beat_t     adc_in,
  input  wire logic                          frame_start,
  // frame buffer side
  output logic                               fb_valid,
  input  wire logic                          fb_ready,
  output pixel_pack_pkg::fb_word_t           fb_word,
  // status
  output logic                               line_busy,
  output logic                               sample_overrun
);
  typedef enum logic {FILL, DRAIN} phase_t;

  typedef struct packed {
    pixel_pack_pkg::adc_beat_t                      sync1;
    pixel_pack_pkg::adc_beat_t                      sync2;
    logic [2:0]                                     fs;
    phase_t                                         phase;
    logic [pixel_pack_pkg::CNT_W-1:0]               count;
    logic [pixel_pack_pkg::CNT_W-1:0]               rd;
    logic                                           step;
    logic [3:0]                                     held;
    logic                                           pattern_gr;
    logic                                           overrun;
    logic [pixel_pack_pkg::LINE_MAX-1:0][pixel_pack_pkg::PIX_W-1:0] line;
  } state_t;

  state_t                           s_reg;
  state_t                           s_next;
  logic                             push;
  logic                             fifo_ready;
  pixel_pack_pkg::fb_word_t         push_word;
  pixel_pack_pkg::packing_t         pk;
  pixel_pack_pkg::pack_out_t        po;
  logic [pixel_pack_pkg::PIX_W-1:0] cur_pix;
  logic [2:0]                       taps;
  logic [pixel_pack_pkg::CNT_W-1:0] beat;

  // bayer codes map onto the mono packing of the same depth
  function automatic pixel_pack_pkg::packing_t decode(input logic [4:0] f);
    logic [4:0] m;
    m = f;
    if (f >= pixel_pack_pkg::FMT_BG8 && f <= pixel_pack_pkg::FMT_BG12P)
      m = f - pixel_pack_pkg::FMT_BG8;
    else if (f >= pixel_pack_pkg::FMT_RG8 && f <= pixel_pack_pkg::FMT_RG12P)
      m = f - pixel_pack_pkg::FMT_RG8;
    case (m)
      pixel_pack_pkg::FMT_MONO10:  decode = pixel_pack_pkg::PK_10;
      pixel_pack_pkg::FMT_MONO10P: decode = pixel_pack_pkg::PK_10P;
      pixel_pack_pkg::FMT_MONO12:  decode = pixel_pack_pkg::PK_12;
      pixel_pack_pkg::FMT_MONO12P: decode = pixel_pack_pkg::PK_12P;
      default:                     decode = pixel_pack_pkg::PK_8;
    endcase
  endfunction

  // yuv codes are not converted here; they fall back to 8-bit bytes
  function automatic pixel_pack_pkg::pack_out_t pack_byte(
    input pixel_pack_pkg::packing_t         k,
    input logic [pixel_pack_pkg::PIX_W-1:0] p,
    input logic [3:0]                       h,
    input logic                             odd,
    input logic                             st
  );
    pack_byte.done = 1'b1;
    pack_byte.data = p[11:4];
    case (k)
      pixel_pack_pkg::PK_10:
      begin
        pack_byte.done = st;
        if (st)
          pack_byte.data = {6'h00, p[3:2]};
      end
      pixel_pack_pkg::PK_12:
      begin
        pack_byte.done = st;
        if (st)
          pack_byte.data = {4'h0, p[3:0]};
      end
      pixel_pack_pkg::PK_10P:
      begin
        if (odd && !st)
        begin
          pack_byte.done = 1'b0;
          pack_byte.data = {2'h0, p[3:2], 2'h0, h[1:0]};
        end
      end
      pixel_pack_pkg::PK_12P:
      begin
        if (odd && !st)
        begin
          pack_byte.done = 1'b0;
          pack_byte.data = {p[3:0], h};
        end
      end
      default:
        pack_byte.done = 1'b1;
    endcase
  endfunction

  // keep the upper bits; the two dropped lsbs carry mostly converter noise
  function automatic logic [pixel_pack_pkg::PIX_W-1:0] trim(
    input logic [pixel_pack_pkg::ADC_W-1:0] s
  );
    trim = s[pixel_pack_pkg::ADC_W-1:pixel_pack_pkg::ADC_DROP];
  endfunction

  // samples per beat; an illegal tap code reads as single tap
  function automatic logic [2:0] taps_of(input logic q, input logic [1:0] t);
    if (q)
      taps_of = 3'h4;
    else if (t == pixel_pack_pkg::TAPS_TWO)
      taps_of = 3'h2;
    else
      taps_of = 3'h1;
  endfunction

  // format and pixel under the read index
  assign pk      = decode(output_packing_select);
  assign taps    = taps_of(quad_channel_select, tap_count_select);
  assign beat    = s_reg.count >> 1;
  assign cur_pix = s_reg.line[s_reg.rd[pixel_pack_pkg::IDX_W-1:0]];
  assign po      = pack_byte(pk, cur_pix, s_reg.held, s_reg.rd[0], s_reg.step);

  // next state: synchronisers, line fill, then byte drain
  always_comb
  begin
    s_next = s_reg;
    push = 1'b0;
    push_word = '0;
    s_next.sync1 = adc_in;
    s_next.sync2 = s_reg.sync1;
    s_next.fs = {s_reg.fs[1:0], frame_start};
    s_next.overrun = 1'b0;
    case (s_reg.phase)
      FILL:
      begin
        if (s_reg.sync2.valid)
        begin
          if (taps == 3'h4)
          begin
            for (int j = 0; j < pixel_pack_pkg::CHANNELS; j++)
              s_next.line[pixel_pack_pkg::IDX_W'(s_reg.count + j)] =
                trim(s_reg.sync2.ch[j]);
          end
          else if (taps == 3'h2)
          begin
            // right amplifier shifts out from the far end inward
            s_next.line[beat[pixel_pack_pkg::IDX_W-1:0]] =
              trim(s_reg.sync2.ch[0]);
            s_next.line[pixel_pack_pkg::IDX_W'(line_width - 1'b1 - beat)] =
              trim(s_reg.sync2.ch[1]);
          end
          else
            s_next.line[s_reg.count[pixel_pack_pkg::IDX_W-1:0]] =
              trim(s_reg.sync2.ch[0]);
          s_next.count = s_reg.count + pixel_pack_pkg::CNT_W'(taps);
          // width is a multiple of four so the sum lands on it exactly
          if (s_reg.count + pixel_pack_pkg::CNT_W'(taps) >= line_width)
          begin
            s_next.phase = DRAIN;
            s_next.rd = '0;
            s_next.step = 1'b0;
          end
        end
      end
      DRAIN:
      begin
        // the converter cannot be stalled, so beats here are lost
        s_next.overrun = s_reg.sync2.valid;
        if (fifo_ready)
        begin
          push = 1'b1;
          push_word.data = po.data;
          push_word.pattern_gr = s_reg.pattern_gr;
          if ((pk == pixel_pack_pkg::PK_10P || pk == pixel_pack_pkg::PK_12P)
              && !s_reg.rd[0])
            s_next.held = cur_pix[3:0] >> ((pk == pixel_pack_pkg::PK_10P)
                                           ? 2 : 0);
          if (po.done)
          begin
            s_next.step = 1'b0;
            s_next.rd = s_reg.rd + 1'b1;
            if (s_reg.rd + 1'b1 >= line_width)
            begin
              push_word.last = 1'b1;
              s_next.phase = FILL;
              s_next.count = '0;
              s_next.pattern_gr = !s_reg.pattern_gr;
            end
          end
          else
            s_next.step = 1'b1;
        end
      end
      default:
        s_next.phase = FILL;
    endcase
    // a new frame always opens on the green-red line
    if (s_reg.fs[1] && !s_reg.fs[2])
      s_next.pattern_gr = pixel_pack_pkg::PATTERN_GR_FIRST;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.pattern_gr <= pixel_pack_pkg::PATTERN_GR_FIRST;
    end
    else
      s_reg <= s_next;
  end

  // status outputs straight from state
  assign line_busy      = (s_reg.phase == DRAIN);
  assign sample_overrun = s_reg.overrun;

  // output buffer absorbs frame buffer stalls
  byte_fifo #(
    .W     (pixel_pack_pkg::FIFO_W),
    .DEPTH (pixel_pack_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (fb_valid),
    .out_ready (fb_ready),
    .out_data  (fb_word)
  );

  // checks on the packing and line sequencing
  sequence line_full;
    s_reg.phase == FILL && s_reg.sync2.valid &&
      s_reg.count + pixel_pack_pkg::CNT_W'(taps) >= line_width;
  endsequence

  sequence line_end;
    push && push_word.last;
  endsequence

  a_release_after_fill: assert property (@(posedge clk) disable iff (rst)
    $rose(s_reg.phase == DRAIN) |-> $past(s_reg.sync2.valid))
    else $error("line released before it was complete");

  a_fill_then_drain: assert property (@(posedge clk) disable iff (rst)
    line_full |=> s_reg.phase == DRAIN && s_reg.rd == '0)
    else $error("full line did not start draining");

  a_mono8_byte: assert property (@(posedge clk) disable iff (rst)
    push && pk == pixel_pack_pkg::PK_8 |->
      push_word.data == cur_pix[11:4] && s_next.rd == s_reg.rd + 1'b1)
    else $error("8-bit byte is not the top pixel bits");

  a_unpack10_pad: assert property (@(posedge clk) disable iff (rst)
    push && pk == pixel_pack_pkg::PK_10 && s_reg.step |->
      push_word.data[7:2] == 6'h00)
    else $error("10-bit second byte has nonzero pad bits");

  a_unpack12_pad: assert property (@(posedge clk) disable iff (rst)
    push && pk == pixel_pack_pkg::PK_12 && s_reg.step |->
      push_word.data == {4'h0, cur_pix[3:0]})
    else $error("12-bit second byte wrong");

  a_pack12_shared: assert property (@(posedge clk) disable iff (rst)
    push && pk == pixel_pack_pkg::PK_12P && s_reg.rd[0] && !s_reg.step |->
      push_word.data == {cur_pix[3:0], s_reg.held})
    else $error("12-bit packed shared byte wrong");

  a_pack10_shared: assert property (@(posedge clk) disable iff (rst)
    push && pk == pixel_pack_pkg::PK_10P && s_reg.rd[0] && !s_reg.step |->
      push_word.data[7:6] == 2'h0 && push_word.data[3:2] == 2'h0 &&
      push_word.data[5:4] == cur_pix[3:2])
    else $error("10-bit packed shared byte wrong");

  a_pattern_toggle: assert property (@(posedge clk) disable iff (rst)
    line_end ##0 !(s_reg.fs[1] && !s_reg.fs[2]) |=>
      s_reg.pattern_gr != $past(s_reg.pattern_gr))
    else $error("bayer line pattern did not alternate");

  a_single_tap_left: assert property (@(posedge clk) disable iff (rst)
    s_reg.phase == FILL && s_reg.sync2.valid && taps == 3'h1 |=>
      s_reg.line[$past(s_reg.count[pixel_pack_pkg::IDX_W-1:0])] ==
        $past(s_reg.sync2.ch[0][13:2]))
    else $error("single tap sample not stored from left channel");

  a_dual_tap_halves: assert property (@(posedge clk) disable iff (rst)
    s_reg.phase == FILL && s_reg.sync2.valid && taps == 3'h2 |=>
      s_reg.line[$past(beat[pixel_pack_pkg::IDX_W-1:0])] ==
        $past(s_reg.sync2.ch[0][13:2]) &&
      s_reg.line[$past(line_width) - 1'b1 - $past(beat)] ==
        $past(s_reg.sync2.ch[1][13:2]))
    else $error("dual tap halves stored in the wrong places");

  a_quad_ordered: assert property (@(posedge clk) disable iff (rst)
    s_reg.phase == FILL && s_reg.sync2.valid && taps == 3'h4 |=>
      s_reg.line[$past(s_reg.count[pixel_pack_pkg::IDX_W-1:0]) + 6'h3] ==
        $past(s_reg.sync2.ch[3][13:2]))
    else $error("fourth channel sample not at its line position");

  a_overrun_in_drain: assert property (@(posedge clk) disable iff (rst)
    sample_overrun |-> $past(s_reg.phase) == DRAIN)
    else $error("overrun flagged outside a line drain");

  a_rd_advances: assert property (@(posedge clk) disable iff (rst)
    push && po.done |=> s_reg.rd == $past(s_reg.rd) + 1'b1)
    else $error("line read index did not step forward");

  a_frame_restart: assert property (@(posedge clk) disable iff (rst)
    s_reg.fs[1] && !s_reg.fs[2] |=>
      s_reg.pattern_gr == pixel_pack_pkg::PATTERN_GR_FIRST)
    else $error("frame start did not restore the green-red line");

  a_stall_holds_word: assert property (@(posedge clk) disable iff (rst)
    fb_valid && !fb_ready |=> fb_valid && $stable(fb_word))
    else $error("frame buffer word changed while stalled");
endmodule

// ==== tb/fb_sink_model.sv ====
// frame buffer sink model: takes packer bytes, optionally stalling
// assumes the packer valid/ready handshake on the rising clock edge
`timescale 1ns/1ps
module fb_sink_model (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // pacing chosen by the bench
  input  wire logic                     slow,
  // packer side
  input  wire logic                     fb_valid,
  output logic                          fb_ready,
  input  wire pixel_pack_pkg::fb_word_t fb_word
);
  pixel_pack_pkg::fb_word_t got[$];
  logic [1:0]               pace_reg;

  // slow mode takes one word in four, so the fifo fills and backs up
  always @(posedge clk)
  begin
    if (rst)
    begin
      pace_reg <= 2'h0;
      fb_ready <= 1'b0;
    end
    else
    begin
      pace_reg <= pace_reg + 2'h1;
      fb_ready <= !slow || (pace_reg == 2'h3);
      if (fb_valid && fb_ready)
        got.push_back(fb_word);
    end
  end
endmodule

// ==== tb/pixel_tap_reorder_packer_tb.sv ====
// self-checking bench: sends whole lines, compares packed bytes
// assumes the sink model in fb_sink_model.sv and the pixel package
`timescale 1ns/1ps
module pixel_tap_reorder_packer_tb;
  logic                             clk;
  logic                             rst;
  logic [1:0]                       tap_count_select;
  logic                             quad_channel_select;
  logic [4:0]                       output_packing_select;
  logic [pixel_pack_pkg::CNT_W-1:0] line_width;
  pixel_pack_pkg::adc_beat_t        adc_in;
  logic                             frame_start;
  logic                             fb_valid;
  logic                             fb_ready;
  pixel_pack_pkg::fb_word_t         fb_word;
  logic                             line_busy;
  logic                             sample_overrun;
  logic                             slow;
  logic                             exp_pat;
  logic [7:0]                       exp_q[$];
  logic [11:0]                      pix[64];
  int                               error_cnt;
  int                               n_checks;
  int                               f;
  int                               n;

  pixel_tap_reorder_packer i_dut (
    .clk                   (clk),
    .rst                   (rst),
    .tap_count_select      (tap_count_select),
    .quad_channel_select   (quad_channel_select),
    .output_packing_select (output_packing_select),
    .line_width            (line_width),
    .adc_in                (adc_in),
    .frame_start           (frame_start),
    .fb_valid              (fb_valid),
    .fb_ready              (fb_ready),
    .fb_word               (fb_word),
    .line_busy             (line_busy),
    .sample_overrun        (sample_overrun)
  );

  fb_sink_model i_sink (
    .clk      (clk),
    .rst      (rst),
    .slow     (slow),
    .fb_valid (fb_valid),
    .fb_ready (fb_ready),
    .fb_word  (fb_word)
  );

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] want,
                       input string what);
    n_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("ERROR %0t %s: saw %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // drive one line of beats; unused channels carry junk on purpose
  task automatic send_line(input logic [1:0] taps, input logic quad,
                           input logic [4:0] fmt, input int width,
                           input logic [11:0] base);
    int                        k;
    int                        nb;
    int                        kind;
    pixel_pack_pkg::adc_beat_t b;
    @(posedge clk);
    tap_count_select <= taps;
    quad_channel_select <= quad;
    output_packing_select <= fmt;
    line_width <= 7'(width);
    for (k = 0; k < width; k++)
      pix[k] = base + 12'(k * 419);
    nb = quad ? width / 4 : (taps == pixel_pack_pkg::TAPS_TWO ? width / 2
                                                              : width);
    for (k = 0; k < nb; k++)
    begin
      b.valid = 1'b1;
      b.ch = {4{14'h2aa5}};
      if (quad)
        for (int j = 0; j < 4; j++)
          b.ch[j] = {pix[4*k+j], 2'h2};
      else
        b.ch[0] = {pix[k], 2'h1};
      if (!quad && taps == pixel_pack_pkg::TAPS_TWO)
        b.ch[1] = {pix[width-1-k], 2'h3};
      @(posedge clk);
      adc_in <= b;
      #1 check(fb_valid, 1'b0, "output before line complete");
    end
    @(posedge clk);
    adc_in.valid <= 1'b0;
    #1 check(line_busy, 1'b0, "busy too early");
    kind = (fmt <= 5'h0e) ? fmt % 5 : 0;
    for (k = 0; k < width; k++)
      case (kind)
        1:
        begin
          exp_q.push_back(pix[k][11:4]);
          exp_q.push_back({6'h00, pix[k][3:2]});
        end
        3:
        begin
          exp_q.push_back(pix[k][11:4]);
          exp_q.push_back({4'h0, pix[k][3:0]});
        end
        2, 4:
          if (k % 2 == 1)
          begin
            exp_q.push_back(pix[k-1][11:4]);
            if (kind == 2)
              exp_q.push_back({2'h0, pix[k][3:2], 2'h0, pix[k-1][3:2]});
            else
              exp_q.push_back({pix[k][3:0], pix[k-1][3:0]});
            exp_q.push_back(pix[k][11:4]);
          end
        default:
          exp_q.push_back(pix[k][11:4]);
      endcase
  endtask

  // wait for the line to drain, then compare every stored byte
  task automatic recv_line(input logic [4:0] fmt);
    int                       k;
    int                       m;
    pixel_pack_pkg::fb_word_t w;
    m = 0;
    while ((i_sink.got.size() < exp_q.size() || line_busy) && m < 3000)
    begin
      @(posedge clk);
      m++;
    end
    check(16'(i_sink.got.size()), 16'(exp_q.size()), "byte count");
    m = exp_q.size();
    for (k = 0; k < m; k++)
    begin
      w = i_sink.got.pop_front();
      check(w.data, exp_q.pop_front(), "byte");
      check(w.last, k == m - 1, "last flag");
      check(w.pattern_gr, exp_pat, "line pattern");
    end
    exp_pat = !exp_pat;
  endtask

  // watchdog sized well past the longest expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    finish_test;
  end

  initial
  begin
    rst = 1'b1;
    tap_count_select = pixel_pack_pkg::TAPS_ONE;
    quad_channel_select = 1'b0;
    output_packing_select = pixel_pack_pkg::FMT_MONO8;
    line_width = 7'h04;
    adc_in = '0;
    frame_start = 1'b0;
    slow = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    exp_pat = pixel_pack_pkg::PATTERN_GR_FIRST;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // every format code on a short single tap line
    for (f = 0; f <= 16; f++)
    begin
      send_line(pixel_pack_pkg::TAPS_ONE, 1'b0, f[4:0], 4,
                12'(f * 97));
      recv_line(f[4:0]);
    end
    // dual tap: right half arrives mirrored on the second channel
    send_line(pixel_pack_pkg::TAPS_TWO, 1'b0, pixel_pack_pkg::FMT_MONO12,
              16, 12'h123);
    recv_line(pixel_pack_pkg::FMT_MONO12);
    // four channels, widest line, packed ten bit
    send_line(pixel_pack_pkg::TAPS_ONE, 1'b1, pixel_pack_pkg::FMT_MONO10P,
              64, 12'hf0d);
    recv_line(pixel_pack_pkg::FMT_MONO10P);
    send_line(pixel_pack_pkg::TAPS_TWO, 1'b0, pixel_pack_pkg::FMT_RG12P,
              8, 12'h9e1);
    recv_line(pixel_pack_pkg::FMT_RG12P);
    // slow sink fills the fifo; a beat during drain must be dropped
    slow <= 1'b1;
    send_line(pixel_pack_pkg::TAPS_ONE, 1'b0, pixel_pack_pkg::FMT_MONO12,
              8, 12'h4b7);
    n = 0;
    while (!line_busy && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    #1 check(line_busy, 1'b1, "line not draining");
    @(posedge clk);
    adc_in.valid <= 1'b1;
    @(posedge clk);
    adc_in.valid <= 1'b0;
    n = 0;
    repeat (8)
    begin
      @(posedge clk);
      #1 n += int'(sample_overrun === 1'b1);
    end
    check(16'(n), 16'h0001, "overrun pulses");
    recv_line(pixel_pack_pkg::FMT_MONO12);
    slow <= 1'b0;
    // frame start forces the green-red line pattern again
    @(posedge clk);
    frame_start <= 1'b1;
    repeat (4) @(posedge clk);
    frame_start <= 1'b0;
    repeat (4) @(posedge clk);
    exp_pat = 1'b1;
    send_line(pixel_pack_pkg::TAPS_ONE, 1'b0, pixel_pack_pkg::FMT_BG8,
              4, 12'h777);
    recv_line(pixel_pack_pkg::FMT_BG8);
    send_line(pixel_pack_pkg::TAPS_ONE, 1'b0, pixel_pack_pkg::FMT_BG8,
              4, 12'h0f3);
    recv_line(pixel_pack_pkg::FMT_BG8);
    finish_test;
  end
endmodule
